/* File: analog_core_model.sv */
// behavioural analog core: answers conversion and calibration requests
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
	input wire logic clock,
	input wire logic slow,
	input wire sar_seq_pkg::conv_req_t req,
	input wire logic convStart,
	input wire logic calibrate,
	output logic convDone,
	output logic [11:0] convData,
	output logic calDone
);
	logic [3:0] cnt_r;
	logic [3:0] calCnt_r;
	// quiet start, no pending work
	initial begin
		{convDone, calDone, cnt_r, calCnt_r} = '0;
		convData = 12'h000;
	end
	// conversion latency countdown, result built from the request fields
	always @(posedge clock) begin
		convDone <= 1'b0;
		convData <= ~convData; // data lines not held between results
		if (convStart) begin
			cnt_r <= slow ? 4'h6 : 4'h1;
		end else if (cnt_r == 4'h1) begin
			cnt_r <= 4'h0;
			convDone <= 1'b1;
			convData <= {req.diff, (req.channel == 3'h7) ? req.src : 2'h0, 6'h00, req.channel};
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
	// calibration ends a few cycles after it is requested
	always @(posedge clock) begin
		calDone <= 1'b0;
		if (!calibrate || calDone) begin
			calCnt_r <= 4'h0;
		end else if (calCnt_r == 4'h3) begin
			calDone <= 1'b1;
		end else begin
			calCnt_r <= calCnt_r + 4'h1;
		end
	end
endmodule : analog_core_model
`default_nettype wire

/* File: result_store.sv */
// per-channel result memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module result_store #(
	parameter int DEPTH = 8,
	parameter int DATA_W = 12,
	parameter int ADDR_W = 3
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic rdEn,
	input wire logic [ADDR_W-1:0] rdAddr,
	output logic [DATA_W-1:0] rdData
);
	logic [DATA_W-1:0] mem [DEPTH];

	// storage, no reset needed since valid bits guard it
	always_ff @(posedge clock) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// read data held in a register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= '0;
		end else if (rdEn) begin
			rdData <= mem[rdAddr];
		end
	end
endmodule : result_store
`default_nettype wire

/* File: sar_adc_sequencer.sv */
// conversion sequencer for the eight-channel successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer #(
	parameter int NUM_CH = sar_seq_pkg::NUM_CH,
	parameter int DATA_W = sar_seq_pkg::DATA_W
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire sar_seq_pkg::mode_t mode,
	input wire logic [NUM_CH-1:0] chanEnable,
	input wire logic [sar_seq_pkg::CH_W-1:0] singleChannel,
	input wire logic diffMode,
	input wire sar_seq_pkg::src_t ch7Source,
	input wire logic startWrite,
	input wire logic haltWrite,
	input wire logic extTrigEnable,
	input wire logic externalTriggerPin,
	input wire logic calStart,
	input wire logic [DATA_W-1:0] compareValue,
	input wire logic [sar_seq_pkg::CH_W-1:0] compareChannel,
	input wire logic compareIntEnable,
	input wire logic compareClear,
	input wire logic doneIntEnable,
	input wire logic doneClear,
	input wire logic readStrobe,
	input wire logic [sar_seq_pkg::CH_W-1:0] readChannel,
	input wire logic convDone,
	input wire logic [DATA_W-1:0] convData,
	input wire logic calDone,
	output sar_seq_pkg::conv_req_t convReq_r,
	output logic convStart_r,
	output logic calibrate_r,
	output logic conversionStartBit_r,
	output logic busy_r,
	output logic doneFlag_r,
	output logic doneIrq_r,
	output logic compareFlag_r,
	output logic compareIrq_r,
	output logic [DATA_W-1:0] readData,
	output logic readValid_r,
	output logic readOverrun_r,
	output logic [NUM_CH-1:0] validVec_r,
	output logic [NUM_CH-1:0] overrunVec_r
);
	localparam int CH_W = sar_seq_pkg::CH_W;
	sar_seq_pkg::state_t state_r;
	logic [CH_W-1:0] curChan_r, singleSel, scanNext;
	logic trigPrev_r, trigEdge, startReq, startTake;
	logic resultDone, seqDone, haltEnd, isSingle, isCont, compareHit;
	logic [NUM_CH-1:0] effMask;
	logic [CH_W:0] firstInfo, nextInfo;
	// lowest enabled channel at or above a start point, found bit on top
	function automatic logic [CH_W:0] nextChan(input logic [NUM_CH-1:0] mask, input logic [CH_W:0] from);
		logic [CH_W:0] res;
		res = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (mask[i] && i >= int'(from)) begin
				res = {1'b1, CH_W'(i)};
			end
		end
		return res;
	endfunction : nextChan
	// trigger edge, pin taken as synchronous
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			trigPrev_r <= 1'b0;
		end else begin
			trigPrev_r <= externalTriggerPin;
		end
	end
	// start sources, channel selection and sequence end decode
	always_comb begin
		trigEdge = externalTriggerPin && !trigPrev_r;
		startReq = startWrite || (extTrigEnable && trigEdge);
		startTake = (state_r == sar_seq_pkg::ST_IDLE) && !calStart && startReq && !haltWrite;
		isSingle = (mode == sar_seq_pkg::MODE_SINGLE);
		isCont = (mode == sar_seq_pkg::MODE_SCAN_CONT);
		effMask = diffMode ? (chanEnable & sar_seq_pkg::DIFF_MASK) : chanEnable;
		singleSel = diffMode ? {1'b0, singleChannel[CH_W-2:0]} : singleChannel;
		firstInfo = nextChan(effMask, '0);
		nextInfo = nextChan(effMask, {1'b0, curChan_r} + 1'b1);
		scanNext = nextInfo[CH_W] ? nextInfo[CH_W-1:0] : firstInfo[CH_W-1:0];
		resultDone = (state_r == sar_seq_pkg::ST_WAIT) && convDone;
		haltEnd = resultDone && !conversionStartBit_r;
		seqDone = (startTake && !isSingle && !firstInfo[CH_W])
			|| (resultDone && conversionStartBit_r
			&& (isSingle || (!isCont && !nextInfo[CH_W]) || (isCont && !firstInfo[CH_W])));
		compareHit = resultDone && (curChan_r == compareChannel) && (convData == compareValue);
	end
	// sequencer state and current channel
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= sar_seq_pkg::ST_IDLE;
			curChan_r <= sar_seq_pkg::CH_FIRST;
		end else begin
			case (state_r)
				sar_seq_pkg::ST_IDLE: begin
					if (calStart) begin
						state_r <= sar_seq_pkg::ST_CAL;
					end else if (startTake && isSingle) begin
						curChan_r <= singleSel;
						state_r <= sar_seq_pkg::ST_ISSUE;
					end else if (startTake && firstInfo[CH_W]) begin
						curChan_r <= firstInfo[CH_W-1:0];
						state_r <= sar_seq_pkg::ST_ISSUE;
					end
				end
				sar_seq_pkg::ST_CAL: begin
					if (calDone) begin
						state_r <= sar_seq_pkg::ST_IDLE;
					end
				end
				sar_seq_pkg::ST_ISSUE: begin
					state_r <= sar_seq_pkg::ST_WAIT;
				end
				sar_seq_pkg::ST_WAIT: begin
					if (haltEnd || seqDone) begin
						state_r <= sar_seq_pkg::ST_IDLE;
					end else if (resultDone) begin
						curChan_r <= scanNext;
						state_r <= sar_seq_pkg::ST_ISSUE;
					end
				end
				default: begin
					state_r <= sar_seq_pkg::ST_IDLE;
				end
			endcase
		end
	end
	// request to the analog core, one start pulse per conversion
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			convReq_r <= sar_seq_pkg::REQ_RST;
			convStart_r <= 1'b0;
		end else begin
			convStart_r <= (state_r == sar_seq_pkg::ST_ISSUE);
			if (state_r == sar_seq_pkg::ST_ISSUE) begin
				convReq_r <= '{channel: curChan_r, diff: diffMode, src: ch7Source};
			end
		end
	end
	// start bit, cleared by halt or by sequence completion
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			conversionStartBit_r <= 1'b0;
		end else if (haltWrite || seqDone) begin
			conversionStartBit_r <= 1'b0;
		end else if (startTake) begin
			conversionStartBit_r <= 1'b1;
		end
	end
	// calibration request held until the core answers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			calibrate_r <= 1'b0;
		end else if (state_r == sar_seq_pkg::ST_IDLE && calStart) begin
			calibrate_r <= 1'b1;
		end else if (state_r == sar_seq_pkg::ST_CAL && calDone) begin
			calibrate_r <= 1'b0;
		end
	end
	// status flags, set wins over clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{busy_r, doneFlag_r, doneIrq_r, compareFlag_r, compareIrq_r} <= 5'h00;
		end else begin
			busy_r <= (state_r != sar_seq_pkg::ST_IDLE);
			if (seqDone) begin
				doneFlag_r <= 1'b1;
			end else if (doneClear) begin
				doneFlag_r <= 1'b0;
			end
			doneIrq_r <= doneFlag_r && doneIntEnable;
			if (compareHit) begin
				compareFlag_r <= 1'b1;
			end else if (compareClear) begin
				compareFlag_r <= 1'b0;
			end
			compareIrq_r <= compareFlag_r && compareIntEnable;
		end
	end
	// per-channel valid and overrun bits
	for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
		logic wrHit;
		logic rdHit;
		assign wrHit = resultDone && (curChan_r == CH_W'(i));
		assign rdHit = readStrobe && (readChannel == CH_W'(i));
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				validVec_r[i] <= 1'b0;
				overrunVec_r[i] <= 1'b0;
			end else begin
				if (wrHit) begin
					validVec_r[i] <= 1'b1;
				end else if (rdHit) begin
					validVec_r[i] <= 1'b0;
				end
				if (wrHit && validVec_r[i] && !rdHit) begin
					overrunVec_r[i] <= 1'b1;
				end else if (rdHit) begin
					overrunVec_r[i] <= 1'b0;
				end
			end
		end
	end
	// read port status captured with the data
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{readValid_r, readOverrun_r} <= 2'h0;
		end else if (readStrobe) begin
			readValid_r <= validVec_r[readChannel];
			readOverrun_r <= overrunVec_r[readChannel];
		end
	end
	// result storage, one word per channel
	result_store #(
		.DEPTH(NUM_CH),
		.DATA_W(DATA_W),
		.ADDR_W(CH_W)
	) u_store (
		.clock(clock),
		.arst_n(arst_n),
		.wrEn(resultDone),
		.wrAddr(curChan_r),
		.wrData(convData),
		.rdEn(readStrobe),
		.rdAddr(readChannel),
		.rdData(readData)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_issue;
		(state_r == sar_seq_pkg::ST_ISSUE) ##1 convStart_r;
	endsequence
	sequence s_finish;
		##1 (!conversionStartBit_r && state_r == sar_seq_pkg::ST_IDLE && doneFlag_r);
	endsequence
	property p_singleStop;
		resultDone && isSingle && conversionStartBit_r && !haltWrite |-> s_finish;
	endproperty
	a_singleStop: assert property (p_singleStop) else $error("single conversion did not stop");
	property p_scanEnabled;
		convStart_r && !diffMode && mode != sar_seq_pkg::MODE_SINGLE |-> chanEnable[convReq_r.channel];
	endproperty
	a_scanEnabled: assert property (p_scanEnabled) else $error("scan converted a disabled channel");
	property p_scanAscend;
		resultDone && conversionStartBit_r && !isSingle && nextInfo[CH_W] && !haltWrite
			|-> ##1 (curChan_r > $past(curChan_r)) ##0 s_issue;
	endproperty
	a_scanAscend: assert property (p_scanAscend) else $error("scan did not step upward");
	property p_contWrap;
		resultDone && conversionStartBit_r && isCont && !nextInfo[CH_W] && firstInfo[CH_W] && !haltWrite
			|-> ##1 s_issue;
	endproperty
	a_contWrap: assert property (p_contWrap) else $error("continuous scan did not restart");
	property p_startBegins;
		startTake && (isSingle || firstInfo[CH_W]) |-> ##1 conversionStartBit_r ##0 s_issue;
	endproperty
	a_startBegins: assert property (p_startBegins) else $error("start did not begin a sequence");
	property p_trigStart;
		state_r == sar_seq_pkg::ST_IDLE && extTrigEnable && trigEdge && !calStart && !haltWrite
			|-> ##1 (conversionStartBit_r || doneFlag_r);
	endproperty
	a_trigStart: assert property (p_trigStart) else $error("trigger edge ignored");
	property p_validSet;
		resultDone |-> ##1 validVec_r[$past(curChan_r)];
	endproperty
	a_validSet: assert property (p_validSet) else $error("result not marked valid");
	property p_overrun;
		resultDone && validVec_r[curChan_r] && !(readStrobe && readChannel == curChan_r)
			|-> ##1 overrunVec_r[$past(curChan_r)];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overwrite not flagged");
	property p_compareIrq;
		compareHit && compareIntEnable ##1 compareIntEnable |-> compareFlag_r ##1 compareIrq_r;
	endproperty
	a_compareIrq: assert property (p_compareIrq) else $error("compare match lost");
	property p_srcSelect;
		convStart_r |-> convReq_r.src == $past(ch7Source);
	endproperty
	a_srcSelect: assert property (p_srcSelect) else $error("source select not passed");
	property p_diffRange;
		convStart_r && convReq_r.diff |-> convReq_r.channel < CH_W'(sar_seq_pkg::DIFF_PAIRS);
	endproperty
	a_diffRange: assert property (p_diffRange) else $error("differential channel out of range");
	property p_calHold;
		state_r == sar_seq_pkg::ST_IDLE && calStart |-> ##1 (calibrate_r && state_r == sar_seq_pkg::ST_CAL)
			##1 (calibrate_r || $past(calDone));
	endproperty
	a_calHold: assert property (p_calHold) else $error("calibration request dropped");
	property p_doneIrq;
		seqDone ##1 doneIntEnable |-> ##1 doneIrq_r;
	endproperty
	a_doneIrq: assert property (p_doneIrq) else $error("done interrupt missing");
endmodule : sar_adc_sequencer
`default_nettype wire

/* File: sar_seq_pkg.sv */
// constants, types and structs shared by the converter sequencer
//
// Behaviour
// - single mode converts one chosen channel, stops
// - one-shot scan converts enabled channels ascending once
// - continuous scan repeats the scan until halted
// - writing start bit begins selected sequence
// - external trigger pin also starts the sequence
// - per-channel result with valid and overrun flags
// - result of the compare channel equal to compare value raises interrupt
// - channel seven selects one of four sources
// - twelve-bit results, eight selectable input channels
// - eight single-ended or four differential pairs
// - software-invoked self-calibration before conversions
`default_nettype none
package sar_seq_pkg;
	localparam int NUM_CH = 8;
	localparam int DATA_W = 12;
	localparam int CH_W = 3;
	localparam int DIFF_PAIRS = 4;
	localparam logic [CH_W-1:0] CH_FIRST = 3'h0;
	localparam logic [CH_W-1:0] CH_SRC_SEL = 3'h7;
	localparam logic [NUM_CH-1:0] DIFF_MASK = 8'h0f;
	localparam logic [DATA_W-1:0] DATA_RST = 12'h000;

	// sequencing modes
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_SCAN_ONCE = 2'h1,
		MODE_SCAN_CONT = 2'h2
	} mode_t;

	// sources for the last channel
	typedef enum logic [1:0] {
		SRC_EXTERNAL = 2'h0,
		SRC_BANDGAP = 2'h1,
		SRC_TEMP = 2'h2,
		SRC_GROUND = 2'h3
	} src_t;

	// sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CAL = 4'h2,
		ST_ISSUE = 4'h4,
		ST_WAIT = 4'h8
	} state_t;

	// request presented to the analog core
	typedef struct packed {
		logic [CH_W-1:0] channel;
		logic diff;
		src_t src;
	} conv_req_t;

	localparam conv_req_t REQ_RST = '{channel: CH_FIRST, diff: 1'b0, src: SRC_EXTERNAL};
endpackage : sar_seq_pkg
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock, arst_n, diffMode, startWrite, haltWrite, extTrigEnable, externalTriggerPin, calStart;
	logic compareIntEnable, compareClear, doneIntEnable, doneClear, readStrobe, slow;
	logic convDone, calDone, convStart, calibrate, startBit, busy, doneFlag, doneIrq, cmpFlag, cmpIrq, rdValid, rdOv;
	sar_seq_pkg::mode_t mode;
	sar_seq_pkg::src_t ch7Source;
	sar_seq_pkg::conv_req_t req;
	sar_seq_pkg::conv_req_t seen[$];
	logic [7:0] chanEnable, validVec, overrunVec;
	logic [2:0] singleChannel, compareChannel, readChannel;
	logic [11:0] compareValue, convData, readData;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;

	sar_adc_sequencer DUT (.clock(clock), .arst_n(arst_n), .mode(mode), .chanEnable(chanEnable),
		.singleChannel(singleChannel), .diffMode(diffMode), .ch7Source(ch7Source), .startWrite(startWrite),
		.haltWrite(haltWrite), .extTrigEnable(extTrigEnable), .externalTriggerPin(externalTriggerPin),
		.calStart(calStart), .compareValue(compareValue), .compareChannel(compareChannel),
		.compareIntEnable(compareIntEnable), .compareClear(compareClear), .doneIntEnable(doneIntEnable),
		.doneClear(doneClear), .readStrobe(readStrobe), .readChannel(readChannel), .convDone(convDone),
		.convData(convData), .calDone(calDone), .convReq_r(req), .convStart_r(convStart),
		.calibrate_r(calibrate), .conversionStartBit_r(startBit), .busy_r(busy), .doneFlag_r(doneFlag),
		.doneIrq_r(doneIrq), .compareFlag_r(cmpFlag), .compareIrq_r(cmpIrq), .readData(readData),
		.readValid_r(rdValid), .readOverrun_r(rdOv), .validVec_r(validVec), .overrunVec_r(overrunVec));
	analog_core_model core (.clock(clock), .slow(slow), .req(req), .convStart(convStart),
		.calibrate(calibrate), .convDone(convDone), .convData(convData), .calDone(calDone));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// log every issued request; cut a hang short
	always @(posedge clock) begin
		if (convStart) seen.push_back(req);
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task tally_and_finish();
		if (n_mismatch == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish

	task chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one-cycle pulse on a software strobe
	task strobe(input int k);
		@(posedge clock);
		case (k)
			0: startWrite <= 1'b1;
			1: haltWrite <= 1'b1;
			2: calStart <= 1'b1;
			3: doneClear <= 1'b1;
			default: compareClear <= 1'b1;
		endcase
		@(posedge clock);
		{startWrite, haltWrite, calStart, doneClear, compareClear} <= '0;
	endtask : strobe

	task wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge clock);
		while ((busy !== 1'b0 || startBit !== 1'b0 || calibrate !== 1'b0) && n < 200) begin
			@(posedge clock);
			n++;
		end
		if (n == 200) chk(12'h001, 12'h000);
		repeat (2) @(posedge clock);
		#1;
	endtask : wait_idle

	task run(input sar_seq_pkg::mode_t m, input logic [7:0] en, input logic [2:0] ch);
		@(posedge clock);
		mode <= m;
		chanEnable <= en;
		singleChannel <= ch;
		seen.delete();
		strobe(0);
		wait_idle();
	endtask : run

	task rd(input logic [2:0] ch, input logic [11:0] d, input logic v, input logic o);
		@(posedge clock);
		readChannel <= ch;
		readStrobe <= 1'b1;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1;
		chk(readData, d);
		chk({10'h0, rdValid, rdOv}, {10'h0, v, o});
	endtask : rd

	task order(input int n, input logic [23:0] lst);
		chk(12'(seen.size()), 12'(n));
		for (int i = 0; i < n; i++) chk({9'h0, seen[i].channel}, {9'h0, lst[3*i +: 3]});
	endtask : order

	// expected result for a channel
	function automatic logic [11:0] ed(input logic d, input logic [1:0] s, input logic [2:0] c);
		return {d, s, 6'h00, c};
	endfunction : ed

	// main sequence
	initial begin
		{arst_n, diffMode, startWrite, haltWrite, extTrigEnable, externalTriggerPin, calStart} = '0;
		{compareIntEnable, compareClear, doneIntEnable, doneClear, readStrobe, slow} = '0;
		{chanEnable, singleChannel, compareChannel, readChannel, compareValue} = '0;
		mode = sar_seq_pkg::MODE_SINGLE;
		ch7Source = sar_seq_pkg::SRC_EXTERNAL;
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		doneIntEnable <= 1'b1;
		// single conversion, done flag and interrupt
		run(sar_seq_pkg::MODE_SINGLE, 8'h00, 3'h3);
		order(1, 24'h3);
		chk({9'h0, startBit, doneFlag, doneIrq}, 12'h003);
		rd(3'h3, 12'h003, 1'b1, 1'b0);
		// ascending one-shot scan with a slow core, then overrun
		slow <= 1'b1;
		run(sar_seq_pkg::MODE_SCAN_ONCE, 8'ha5, 3'h0);
		order(4, 24'hf50);
		chk({4'h0, validVec}, 12'h0a5);
		run(sar_seq_pkg::MODE_SCAN_ONCE, 8'ha5, 3'h0);
		chk({4'h0, overrunVec}, 12'h0a5);
		rd(3'h7, 12'h007, 1'b1, 1'b1);
		@(posedge clock);
		#1;
		chk({4'h0, overrunVec}, 12'h025);
		slow <= 1'b0;
		// every source of the last channel
		for (int s = 0; s < 4; s++) begin
			ch7Source <= sar_seq_pkg::src_t'(s);
			run(sar_seq_pkg::MODE_SINGLE, 8'h00, 3'h7);
			chk({10'h0, seen[0].src}, 12'(s));
			rd(3'h7, ed(1'b0, 2'(s), 3'h7), 1'b1, 1'b0);
		end
		// differential pairs limit the channels
		diffMode <= 1'b1;
		run(sar_seq_pkg::MODE_SCAN_ONCE, 8'hff, 3'h0);
		order(4, 24'h688);
		chk({11'h0, seen[3].diff}, 12'h001);
		run(sar_seq_pkg::MODE_SINGLE, 8'h00, 3'h6);
		order(1, 24'h2);
		diffMode <= 1'b0;
		// compare hit, then miss
		compareChannel <= 3'h2;
		compareValue <= 12'h002;
		compareIntEnable <= 1'b1;
		run(sar_seq_pkg::MODE_SINGLE, 8'h00, 3'h2);
		chk({10'h0, cmpFlag, cmpIrq}, 12'h003);
		strobe(4);
		compareValue <= 12'h003;
		run(sar_seq_pkg::MODE_SINGLE, 8'h00, 3'h2);
		chk({11'h0, cmpFlag}, 12'h000);
		// start from the trigger pin
		@(posedge clock);
		extTrigEnable <= 1'b1;
		singleChannel <= 3'h5;
		seen.delete();
		@(posedge clock);
		externalTriggerPin <= 1'b1;
		wait_idle();
		order(1, 24'h5);
		externalTriggerPin <= 1'b0;
		extTrigEnable <= 1'b0;
		// continuous scan wraps until halted, no done flag
		strobe(3);
		@(posedge clock);
		mode <= sar_seq_pkg::MODE_SCAN_CONT;
		chanEnable <= 8'h06;
		seen.delete();
		strobe(0);
		repeat (200) if (seen.size() < 5) @(posedge clock);
		strobe(1);
		wait_idle();
		chk({11'h0, seen.size() >= 5}, 12'h001);
		for (int i = 0; i < seen.size(); i++) chk({9'h0, seen[i].channel}, {11'h0, i[0]} + 12'h001);
		chk({11'h0, doneFlag}, 12'h000);
		// self-calibration issues no conversion
		seen.delete();
		strobe(2);
		#1;
		chk({11'h0, calibrate}, 12'h001);
		@(posedge clock);
		#1;
		chk({11'h0, busy}, 12'h001);
		wait_idle();
		chk({11'h0, calibrate}, 12'h000);
		chk(12'(seen.size()), 12'h000);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
